/* File: hdl/asp_ctrl.sv */
// Purpose: host controller for an asynchronous 16-bit static memory
// Assumes: one request at a time; memory pins synchronous to clk
// Notes:   pin outputs registered except lane enables and dq_oe_n, which are gated from registers; dq is split into in, out, enable
`timescale 1ns/1ps
module asp_ctrl (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          resetn,
    // User request
    input  wire asp_pkg::asp_req_s             req,
    output logic                               req_ready,
    output logic                               rd_valid,
    output logic      [asp_pkg::DATA_W-1:0]    rd_data,
    // Memory pins
    output logic                               select_primary_n,
    output logic                               select_secondary,
    output logic                               strobe_n,
    output logic                               gate_n,
    output logic                               upper_lane_enable_n,
    output logic                               lower_lane_enable_n,
    output logic      [asp_pkg::ADDR_W-1:0]    addr,
    output logic      [asp_pkg::DATA_W-1:0]    dq_out,
    output logic      [asp_pkg::DATA_W-1:0]    dq_oe_n,
    input  wire logic [asp_pkg::DATA_W-1:0]    dq_in
);
    typedef struct packed {
        asp_pkg::asp_state_e               st;
        logic [2:0]                        cnt;
        logic [2:0]                        cyc;
        logic                              wr;
        logic [asp_pkg::LANES-1:0]         lanes;
        logic [asp_pkg::ADDR_W-1:0]        addr;
        logic [asp_pkg::DATA_W-1:0]        wdata;
        logic                              sel;
        logic                              strobe;
        logic                              gate;
        logic                              rvalid;
        logic [asp_pkg::DATA_W-1:0]        rdata;
    } asp_ctrl_s;

    asp_ctrl_s s_q;
    asp_ctrl_s s_d;
    logic [asp_pkg::DATA_W-1:0] oe_n_w;

    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        s_d.cnt = (s_q.cnt != 3'h0) ? s_q.cnt - 3'h1 : 3'h0;
        s_d.cyc = (s_q.cyc != 3'h0) ? s_q.cyc - 3'h1 : 3'h0;
        unique case (s_q.st)
            asp_pkg::ASP_IDLE: begin
                if (req.valid && req.lanes != 2'h0) begin
                    s_d.wr     = req.write;
                    s_d.lanes  = req.lanes;
                    s_d.addr   = req.addr;
                    s_d.wdata  = req.wdata;
                    s_d.sel    = 1'b1;
                    s_d.strobe = req.write;
                    s_d.gate   = ~req.write;
                    s_d.cnt    = req.write ? asp_pkg::WR_CNT
                                           : asp_pkg::RD_CNT;
                    s_d.cyc    = req.write ? asp_pkg::WC_CNT
                                           : asp_pkg::RC_CNT;
                    s_d.st     = req.write ? asp_pkg::ASP_WRITE
                                           : asp_pkg::ASP_READ;
                end
            end
            asp_pkg::ASP_READ: begin
                if (s_q.cnt == 3'h0) begin
                    s_d.rdata  = dq_in;
                    s_d.rvalid = 1'b1;
                    s_d.gate   = 1'b0;
                    s_d.sel    = 1'b0;
                    s_d.st     = asp_pkg::ASP_HOLD;
                end
            end
            asp_pkg::ASP_WRITE: begin
                if (s_q.cnt == 3'h0) begin
                    s_d.strobe = 1'b0;
                    s_d.sel    = 1'b0;
                    s_d.st     = asp_pkg::ASP_HOLD;
                end
            end
            asp_pkg::ASP_HOLD: begin
                if (s_q.cyc == 3'h0) begin
                    s_d.wr = 1'b0;
                    s_d.st = asp_pkg::ASP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // hold past ending edge
    // Data driven through the hold state so it outlasts the ending edge
    asp_lane_drv u_drv (
        .drive (s_q.wr),
        .lanes (s_q.lanes),
        .oe_n  (oe_n_w)
    );

    assign select_primary_n    = ~s_q.sel;
    assign select_secondary    = s_q.sel;
    assign strobe_n            = ~s_q.strobe;
    assign gate_n              = ~s_q.gate;
    assign upper_lane_enable_n = ~(s_q.sel & s_q.lanes[1]);
    assign lower_lane_enable_n = ~(s_q.sel & s_q.lanes[0]);
    assign addr                = s_q.addr;
    assign dq_out              = s_q.wdata;
    assign dq_oe_n             = oe_n_w;
    assign req_ready           = (s_q.st == asp_pkg::ASP_IDLE);
    assign rd_valid            = s_q.rvalid;
    assign rd_data             = s_q.rdata;

    write_start_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !strobe_n |-> !select_primary_n && select_secondary
            && !(upper_lane_enable_n && lower_lane_enable_n))
        else $error("strobe low without select and lane");
    read_strobe_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !gate_n |-> strobe_n)
        else $error("strobe low during read");
    strobe_width_a: assert property (
        @(posedge clk) disable iff (!resetn)
        $fell(strobe_n) |-> !strobe_n [*2])
        else $error("write pulse too short");
    data_hold_a: assert property (
        @(posedge clk) disable iff (!resetn)
        $rose(strobe_n) |-> $stable(dq_out) && $stable(addr))
        else $error("data or address changed at write end");
    addr_stable_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !strobe_n && !$past(strobe_n) |-> $stable(addr))
        else $error("address moved in write");
    lane_drive_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !gate_n |-> &dq_oe_n)
        else $error("controller drives pins during read");
    read_access_a: assert property (
        @(posedge clk) disable iff (!resetn)
        $fell(gate_n) |-> ##3 rd_valid)
        else $error("read sampled at wrong time");
    lanes_off_a: assert property (
        @(posedge clk) disable iff (!resetn)
        select_primary_n |-> upper_lane_enable_n && lower_lane_enable_n)
        else $error("lane enable active while deselected");
    cycle_len_a: assert property (
        @(posedge clk) disable iff (!resetn)
        $fell(select_primary_n) |-> !req_ready [*2])
        else $error("access shorter than cycle minimum");
    data_drive_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !strobe_n |-> dq_oe_n == {{8{upper_lane_enable_n}},
                                  {8{lower_lane_enable_n}}})
        else $error("write data not driven on active lanes");
    end_drive_a: assert property (
        @(posedge clk) disable iff (!resetn)
        $rose(strobe_n) |-> !(&dq_oe_n) && $stable(dq_oe_n))
        else $error("write data released at write end");
    lane_steady_a: assert property (
        @(posedge clk) disable iff (!resetn)
        select_primary_n && $past(select_primary_n)
            |-> $stable(upper_lane_enable_n)
            && $stable(lower_lane_enable_n))
        else $error("lane enable toggled while deselected");
    addr_access_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !select_primary_n && !$past(select_primary_n)
            |-> $stable(addr))
        else $error("address moved while selected");
    hold_gap_a: assert property (
        @(posedge clk) disable iff (!resetn)
        $rose(select_primary_n) |-> !req_ready)
        else $error("no recovery cycle after access");
    read_sample_a: assert property (
        @(posedge clk) disable iff (!resetn)
        rd_valid |-> !$past(gate_n) && !$past(select_primary_n))
        else $error("read data taken without gate and select");
    write_gate_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !strobe_n |-> gate_n)
        else $error("output gate low during write");
    strobe_end_a: assert property (
        @(posedge clk) disable iff (!resetn)
        $rose(strobe_n) |-> $rose(select_primary_n))
        else $error("write not ended by strobe and select");
    lanes_used_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !select_primary_n
            |-> !(upper_lane_enable_n && lower_lane_enable_n))
        else $error("selected with both lanes off");

    read_cov: cover property (@(posedge clk) rd_valid);
    write_cov: cover property (@(posedge clk) $rose(strobe_n));
    upper_cov: cover property (@(posedge clk)
        !strobe_n && lower_lane_enable_n);
    lower_cov: cover property (@(posedge clk)
        !strobe_n && upper_lane_enable_n);
    part_read_cov: cover property (@(posedge clk)
        !gate_n && upper_lane_enable_n);
endmodule

/* File: hdl/asp_pkg.sv */
// Purpose: constants and carriers for the static memory word port controller
// Assumes: 40 MHz clock, 45 ns speed grade by default
// Notes:   times in ns, cycle counts derived below
// Operation
// - Deselect by chip select inactive or both lane enables inactive.
// - Data setup and hold measured from the edge that ends the write.
// - Write strobe stays high for the whole read cycle.
// - Lane enables stay steady while chip select is inactive.
// - Address set at write start, 35/40 ns before end, held after end.
// - Write data valid 25 ns before write end, held after it.
// - Active lane enable low at least 35/40 ns before write end.
// - Retention may follow deselect with no delay.
package asp_pkg;
    localparam int CLK_PERIOD_NS      = 25;
    localparam int ADDR_W             = 18;
    localparam int DATA_W             = 16;
    localparam int LANES              = 2;
    // 45 ns grade figures
    localparam int READ_CYCLE_MIN_NS  = 45;
    localparam int ADDRESS_ACCESS_NS  = 45;
    localparam int GATE_ACCESS_NS     = 22;
    localparam int STROBE_PULSE_NS    = 35;
    localparam int WRITE_PERIOD_NS    = 45;
    localparam int DATA_SETUP_NS      = 25;
    // Least times round up
    localparam int READ_CYC  =
        (READ_CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC =
        (ADDRESS_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GATE_CYC =
        (GATE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC =
        (STROBE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC =
        (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC =
        (WRITE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Read waits for address and gate access, plus one sample edge
    localparam int RD_WAIT  = (ACCESS_CYC > GATE_CYC) ? ACCESS_CYC : GATE_CYC;
    localparam int ST_WAIT  =
        (STROBE_CYC > SETUP_CYC) ? STROBE_CYC : SETUP_CYC;
    localparam logic [2:0] RD_CNT  = 3'(RD_WAIT);
    localparam logic [2:0] WR_CNT  = 3'(ST_WAIT);
    localparam logic [2:0] RC_CNT  = 3'(READ_CYC);
    localparam logic [2:0] WC_CNT  = 3'(WRITE_CYC);

    typedef enum logic [2:0] {ASP_IDLE, ASP_READ, ASP_WRITE, ASP_HOLD}
        asp_state_e;

    typedef struct packed {
        logic                  sel_n;
        logic                  sel2;
        logic                  strobe_n;
        logic                  gate_n;
        logic                  upper_n;
        logic                  lower_n;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     dout;
        logic [DATA_W-1:0]     dq_oe_n;
    } asp_pins_s;

    typedef struct packed {
        logic                  valid;
        logic                  write;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     wdata;
        logic [LANES-1:0]      lanes;
    } asp_req_s;
endpackage

/* File: hdl/asp_lane_drv.sv */
// Purpose: per-bit data pin driver with lane gating
// Assumes: enable low means the controller drives the pin
// Notes:   write data come from the main state register
`timescale 1ns/1ps
module asp_lane_drv (
    // Control
    input  wire logic                         drive,
    input  wire logic [asp_pkg::LANES-1:0]    lanes,
    // Pin enables
    output logic      [asp_pkg::DATA_W-1:0]   oe_n
);
    genvar i;
    generate
        for (i = 0; i < asp_pkg::DATA_W; i++) begin : g_bit
            assign oe_n[i] = ~(drive & lanes[i / 8]);
        end
    endgenerate
endmodule

/* File: testbench/asp_mem_model.sv */
// Purpose: behavioural 16-bit static memory seen by the controller
// Assumes: pins change just after clk edges; clk steps the junk and clocks the writes
// Notes:   undriven lanes show a pattern that moves every cycle
`timescale 1ns/1ps
module asp_mem_model #(
    parameter int ACC_NS = 45
) (
    // Clock
    input  wire logic        clk,
    // Controls
    input  wire logic        select_primary_n,
    input  wire logic        select_secondary,
    input  wire logic        strobe_n,
    input  wire logic        gate_n,
    input  wire logic        upper_lane_enable_n,
    input  wire logic        lower_lane_enable_n,
    // Address and data
    input  wire logic [17:0] addr,
    input  wire logic [15:0] dq_out,
    input  wire logic [15:0] dq_oe_n,
    output logic      [15:0] dq_drv
);
    logic [15:0] mem [0:262143];
    logic [15:0] junk = 16'h3B1F;
    logic [15:0] word;
    logic [15:0] live;
    logic        sel;
    logic [15:0] pins;
    assign sel = !select_primary_n && select_secondary;
    // Undriven bits read as the moving pattern, so an idle lane is caught
    assign pins = (dq_out & ~dq_oe_n) | (junk & dq_oe_n);
    always @(posedge clk) begin
        junk <= {junk[14:0], junk[15] ^ junk[13]} ^ 16'h0101;
        if (sel && !strobe_n && !lower_lane_enable_n)
            mem[addr][7:0] <= pins[7:0];
        if (sel && !strobe_n && !upper_lane_enable_n)
            mem[addr][15:8] <= pins[15:8];
    end
    // drive only a selected, gated read lane
    always_comb begin
        word = mem[addr];
        live = junk;
        if (sel && strobe_n && !gate_n && !lower_lane_enable_n)
            live[7:0] = word[7:0];
        if (sel && strobe_n && !gate_n && !upper_lane_enable_n)
            live[15:8] = word[15:8];
    end
    // slowest legal access, old value kept meanwhile
    always @(live) dq_drv <= #(ACC_NS) live;
endmodule

/* File: testbench/async_sram_word_port_tb_top.sv */
// Purpose: self-checking bench for the static memory controller
// Assumes: one request at a time, inputs moved on falling edges
// Notes:   data checked by write then read back through the model
`timescale 1ns/1ps
module async_sram_word_port_tb_top;
    logic              clk;
    logic              resetn;
    asp_pkg::asp_req_s req;
    logic              req_ready, rd_valid, sp_n, ss, st_n, g_n, u_n, l_n;
    logic       [17:0] addr;
    logic       [15:0] rd_data, dq_out, dq_oe_n, dq_in, mem_dq;
    int                failures = 0;
    int                tests_run = 0;

    // Wire level: controller wins where it drives
    assign dq_in = (dq_out & ~dq_oe_n) | (mem_dq & dq_oe_n);

    asp_ctrl dut (.clk(clk), .resetn(resetn), .req(req),
        .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
        .select_primary_n(sp_n), .select_secondary(ss), .strobe_n(st_n),
        .gate_n(g_n), .upper_lane_enable_n(u_n),
        .lower_lane_enable_n(l_n), .addr(addr), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n), .dq_in(dq_in));

    asp_mem_model mem (.clk(clk), .select_primary_n(sp_n),
        .select_secondary(ss), .strobe_n(st_n), .gate_n(g_n),
        .upper_lane_enable_n(u_n), .lower_lane_enable_n(l_n),
        .addr(addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_drv(mem_dq));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic acc(input logic w, input logic [17:0] a,
                       input logic [15:0] d, input logic [1:0] ln);
        int n;
        n = 0;
        @(negedge clk);
        while (!req_ready) @(negedge clk);
        req = '{1'b1, w, a, d, ln};
        @(negedge clk);
        req.valid = 1'b0;
        while (!(w ? req_ready : rd_valid) && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk(16'(n < 20), 16'h0001);
    endtask

    task automatic rd(input logic [17:0] a, input logic [1:0] ln,
                      input logic [15:0] m, input logic [15:0] e);
        acc(1'b0, a, 16'h0000, ln);
        chk(rd_data & m, e & m);
    endtask

    task automatic t_idle;
        chk({8'h00, sp_n, ss, st_n, g_n, u_n, l_n, req_ready, rd_valid},
            16'h00BE);
        chk(dq_oe_n, 16'hFFFF);
    endtask

    task automatic t_word;
        acc(1'b1, 18'h00000, 16'hC3A5, 2'b11);
        acc(1'b1, 18'h3FFFF, 16'h5A3C, 2'b11);
        rd(18'h00000, 2'b11, 16'hFFFF, 16'hC3A5);
        rd(18'h3FFFF, 2'b11, 16'hFFFF, 16'h5A3C);
    endtask

    task automatic t_lanes;
        acc(1'b1, 18'h00005, 16'h1111, 2'b11);
        acc(1'b1, 18'h00005, 16'hAAA2, 2'b01);
        acc(1'b1, 18'h00005, 16'h3CBB, 2'b10);
        rd(18'h00005, 2'b11, 16'hFFFF, 16'h3CA2);
        rd(18'h00005, 2'b01, 16'h00FF, 16'h00A2);
        rd(18'h00005, 2'b10, 16'hFF00, 16'h3C00);
    endtask

    task automatic t_nolane;
        @(negedge clk);
        req = '{1'b1, 1'b1, 18'h00005, 16'hFFFF, 2'b00};
        repeat (4) @(negedge clk);
        t_idle();
        req.valid = 1'b0;
    endtask

    task automatic t_midreset;
        @(negedge clk);
        req = '{1'b1, 1'b1, 18'h00007, 16'h5A5A, 2'b11};
        @(negedge clk);
        req.valid = 1'b0;
        resetn = 1'b0;
        @(negedge clk);
        t_idle();
        resetn = 1'b1;
    endtask

    // Selected cycles: no strobe with gate low, no pin fight on reads
    always @(negedge clk) begin
        if (resetn && !sp_n && ss && !g_n) begin
            chk({15'h0000, st_n}, 16'h0001);
            chk(dq_oe_n, 16'hFFFF);
        end
    end

    initial begin
        req = '0;
        resetn = 1'b0;
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        t_idle();
        t_word();
        t_lanes();
        t_nolane();
        t_midreset();
        t_lanes();
        stop_test();
    end

    // Whole run is some 110 cycles; the 2000-cycle limit lies far above this
    initial begin
        #50000;
        failures++;
        stop_test();
    end
endmodule
